// ==== hdl/dtc_readout.sv ====
// smbus slave and result registers of the dual temperature readout
// assumes scl and sda pins from the host; raw readings on the core clock
`timescale 1ns/100ps
module dtc_readout #(
  parameter logic [6:0] SLAVE_ADDR = dtc_pkg::SLAVE_ADDR_DEFAULT,
  parameter int unsigned CONV_CYCLES = dtc_pkg::CONV_CYC,
  parameter int unsigned TIMEOUT_CYCLES = dtc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // smbus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // analog front end
  input wire dtc_pkg::dtc_meas_t meas_i,
  output logic conv_start_o,
  output logic conv_busy_o
);
  import dtc_pkg::*;

  typedef enum logic [3:0] {
    SB_IDLE, SB_ADDR, SB_ACK_ADDR, SB_CMD, SB_ACK_CMD,
    SB_WDATA, SB_ACK_WDATA, SB_RDATA, SB_RACK, SB_IGNORE
  } dtc_sb_state_t;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic dtc_temp_t to_temp(input logic [11:0] raw, input logic fault);
    dtc_temp_t t;
    t = '0;
    if (fault)
      t.whole = FAULT_WHOLE;
    else if (!raw[11])
      t = raw[10:0];
    return t;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s && !scl_prev_reg;
  wire scl_fall = !scl_s && scl_prev_reg;
  wire start_det = scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
  wire stop_det = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  dtc_sb_state_t sb_state_reg;
  dtc_sb_state_t sb_state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic full_reg;
  logic full_next;
  logic rw_reg;
  logic rw_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic [7:0] ptr_reg;
  logic [7:0] config_reg;
  logic [2:0] rate_reg;
  logic [31:0] low_cnt_reg;
  dtc_temp_t local_t_reg;
  dtc_temp_t remote_t_reg;
  logic cmd_p;
  logic wr_p;

  wire conv_done;
  wire standby = config_reg[CFG_STANDBY_BIT];
  wire timeout = (low_cnt_reg >= 32'(TIMEOUT_CYCLES));
  wire oneshot_p = cmd_p && (shift_reg == REG_ONESHOT);
  wire cfg_wr = wr_p && (ptr_reg == REG_CONFIG_WR);
  wire rate_wr = wr_p && (ptr_reg == REG_RATE_WR);
  wire standby_cmd = cfg_wr && shift_reg[CFG_STANDBY_BIT];
  wire [7:0] status_byte = {conv_busy_o, 7'h0};

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // results stay visible while a sequence runs; only conv_done moves them
  wire [7:0] rd_byte =
    (ptr_reg == REG_LOCAL_INT) ? local_t_reg.whole :
    (ptr_reg == REG_REMOTE_INT) ? remote_t_reg.whole :
    (ptr_reg == REG_REMOTE_FRAC) ? {remote_t_reg.frac, 5'h0} :
    (ptr_reg == REG_LOCAL_FRAC) ? {local_t_reg.frac, 5'h0} :
    (ptr_reg == REG_STATUS) ? status_byte :
    (ptr_reg == REG_CONFIG_RD) ? config_reg :
    (ptr_reg == REG_RATE_RD) ? {5'h0, rate_reg} : 8'h00;

  // ---------------------------------------------------------------
  // serial state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    sb_state_next = sb_state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    full_next = full_reg;
    rw_next = rw_reg;
    sda_oe_next = sda_oe_reg;
    cmd_p = 1'b0;
    wr_p = 1'b0;
    // a stuck host must not hold sda low forever
    if (timeout || stop_det)
    begin
      sb_state_next = SB_IDLE;
      sda_oe_next = 1'b0;
    end
    else if (start_det)
    begin
      sb_state_next = SB_ADDR;
      bit_cnt_next = 3'h0;
      full_next = 1'b0;
      sda_oe_next = 1'b0;
    end
    else
    begin
      case (sb_state_reg)
        SB_ADDR, SB_CMD, SB_WDATA:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 3'h1;
            full_next = (bit_cnt_reg == 3'h7);
          end
          else if (scl_fall && full_reg)
          begin
            full_next = 1'b0;
            sda_oe_next = 1'b1;
            if (sb_state_reg == SB_ADDR)
            begin
              rw_next = shift_reg[0];
              sb_state_next = (shift_reg[7:1] == SLAVE_ADDR) ? SB_ACK_ADDR : SB_IGNORE;
              sda_oe_next = (shift_reg[7:1] == SLAVE_ADDR);
            end
            else if (sb_state_reg == SB_CMD)
            begin
              sb_state_next = SB_ACK_CMD;
              cmd_p = 1'b1;
            end
            else
            begin
              sb_state_next = SB_ACK_WDATA;
              wr_p = 1'b1;
            end
          end
        end
        SB_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            bit_cnt_next = 3'h0;
            if (rw_reg)
            begin
              // receive byte and read byte both use the shared pointer
              sb_state_next = SB_RDATA;
              shift_next = rd_byte;
              sda_oe_next = !rd_byte[7];
            end
            else
            begin
              sb_state_next = SB_CMD;
              sda_oe_next = 1'b0;
            end
          end
        end
        SB_ACK_CMD:
        begin
          if (scl_fall)
          begin
            // stop here makes a send byte; more clocks make a write byte
            sb_state_next = SB_WDATA;
            bit_cnt_next = 3'h0;
            sda_oe_next = 1'b0;
          end
        end
        SB_ACK_WDATA:
        begin
          if (scl_fall)
          begin
            sb_state_next = SB_IGNORE;
            sda_oe_next = 1'b0;
          end
        end
        SB_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_reg == 3'h7)
            begin
              sb_state_next = SB_RACK;
              sda_oe_next = 1'b0;
            end
            else
            begin
              shift_next = {shift_reg[6:0], 1'b0};
              sda_oe_next = !shift_reg[6];
              bit_cnt_next = bit_cnt_reg + 3'h1;
            end
          end
        end
        SB_RACK:
        begin
          if (scl_rise)
          begin
            full_next = !sda_s;
            if (sda_s)
              sb_state_next = SB_IGNORE;
          end
          else if (scl_fall && full_reg)
          begin
            full_next = 1'b0;
            sb_state_next = SB_RDATA;
            bit_cnt_next = 3'h0;
            shift_next = rd_byte;
            sda_oe_next = !rd_byte[7];
          end
        end
        SB_IDLE, SB_IGNORE:
        begin
          sda_oe_next = 1'b0;
        end
        default:
        begin
          sb_state_next = SB_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sb_state_reg <= SB_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      full_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      sb_state_reg <= sb_state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      full_reg <= full_next;
      rw_reg <= rw_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // low time only counts inside a transfer
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      low_cnt_reg <= 32'h0;
    else if (scl_s || sb_state_reg == SB_IDLE || timeout)
      low_cnt_reg <= 32'h0;
    else
      low_cnt_reg <= low_cnt_reg + 32'h1;
  end

  // ---------------------------------------------------------------
  // pointer, control and result registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ptr_reg <= REG_LOCAL_INT;
      config_reg <= CONFIG_RESET;
      rate_reg <= RATE_RESET;
    end
    else
    begin
      if (cmd_p)
        ptr_reg <= shift_reg;
      if (cfg_wr)
        config_reg <= shift_reg;
      if (rate_wr)
        rate_reg <= shift_reg[2:0];
    end
  end

  // both channels and both bytes move on one edge
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      local_t_reg <= '0;
      remote_t_reg <= '0;
    end
    else if (conv_done)
    begin
      local_t_reg <= to_temp(meas_i.local_raw, 1'b0);
      remote_t_reg <= to_temp(meas_i.remote_raw, meas_i.fault);
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  dtc_conv_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_seq (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .standby_i(standby),
    .standby_cmd_i(standby_cmd),
    .oneshot_i(oneshot_p),
    .rate_i(rate_reg),
    .busy_o(conv_busy_o),
    .start_o(conv_start_o),
    .done_o(conv_done)
  );

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_hold;
    !conv_done |=> $stable(local_t_reg) && $stable(remote_t_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("results moved without completion");

  property p_latch;
    conv_done && !meas_i.fault && !meas_i.remote_raw[11] && !meas_i.local_raw[11]
      |=> {local_t_reg, remote_t_reg} == {$past(meas_i.local_raw[10:0]),
                                          $past(meas_i.remote_raw[10:0])};
  endproperty
  a_latch: assert property (p_latch) else $error("results not latched together");

  property p_fault;
    conv_done && meas_i.fault |=> remote_t_reg.whole == 8'hff && remote_t_reg.frac == 3'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("fault code missing");

  property p_negative;
    conv_done && meas_i.local_raw[11] |=> local_t_reg == '0;
  endproperty
  a_negative: assert property (p_negative) else $error("negative not clamped");

  property p_pointer;
    cmd_p |=> ptr_reg == $past(shift_reg);
  endproperty
  a_pointer: assert property (p_pointer) else $error("pointer not replaced");

  property p_msb_first;
    (sb_state_reg == SB_ACK_ADDR && scl_fall && rw_reg && !timeout && !start_det && !stop_det)
      |=> sda_oe_o == !$past(rd_byte[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

  property p_status_busy;
    ptr_reg == REG_STATUS |-> rd_byte[STATUS_BUSY_BIT] == conv_busy_o;
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("busy flag wrong");

  property p_timeout;
    timeout |=> sb_state_reg == SB_IDLE && !sda_oe_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout left bus busy");

  property p_standby_serial;
    (standby && start_det && !timeout) |=> sb_state_reg == SB_ADDR;
  endproperty
  a_standby_serial: assert property (p_standby_serial) else $error("bus dead in standby");

  property p_oneshot_cmd;
    (oneshot_p && !conv_busy_o) |=> conv_busy_o;
  endproperty
  a_oneshot_cmd: assert property (p_oneshot_cmd) else $error("one-shot not started");

  c_done: cover property (conv_done);
  c_receive_byte: cover property (sb_state_reg == SB_ACK_ADDR && rw_reg ##[1:400] sb_state_reg == SB_RDATA);
  c_config_write: cover property (cfg_wr);
endmodule

// ==== pkg/dtc_pkg.sv ====
// constants, field layouts and carrier types of the dual temperature readout
// assumes a 20 MHz core clock and an smbus host on the two serial pins
package dtc_pkg;

  // ---------------------------------------------------------------
  // command codes and register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_LOCAL_INT = 8'h00;
  localparam logic [7:0] REG_REMOTE_INT = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG_RD = 8'h03;
  localparam logic [7:0] REG_RATE_RD = 8'h04;
  localparam logic [7:0] REG_CONFIG_WR = 8'h09;
  localparam logic [7:0] REG_RATE_WR = 8'h0a;
  localparam logic [7:0] REG_ONESHOT = 8'h0f;
  localparam logic [7:0] REG_REMOTE_FRAC = 8'h10;
  localparam logic [7:0] REG_LOCAL_FRAC = 8'h11;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CFG_STANDBY_BIT = 6;
  localparam int STATUS_BUSY_BIT = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [2:0] RATE_RESET = 3'h7;
  localparam logic [2:0] RATE_MAX = 3'h7;
  localparam logic [7:0] FAULT_WHOLE = 8'hff;
  // arbitrary value
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2a;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CONV_TIME_MS = 125;
  localparam int unsigned CONV_CYC = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // raw readings in 0.125 degree steps, two's complement
  typedef struct packed {
    logic fault;
    logic [11:0] local_raw;
    logic [11:0] remote_raw;
  } dtc_meas_t;

  typedef struct packed {
    logic [7:0] whole;
    logic [2:0] frac;
  } dtc_temp_t;

endpackage

// ==== hdl/dtc_conv_seq.sv ====
// conversion sequencer: rate timer, one-shot start, standby abort
// assumes pulses on the same clock from the serial register logic
`timescale 1ns/100ps
module dtc_conv_seq #(
  parameter int unsigned CONV_CYCLES = dtc_pkg::CONV_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // control
  input wire logic standby_i,
  input wire logic standby_cmd_i,
  input wire logic oneshot_i,
  input wire logic [2:0] rate_i,
  // status
  output logic busy_o,
  output logic start_o,
  output logic done_o
);
  import dtc_pkg::*;

  typedef enum logic {CV_IDLE, CV_RUN} dtc_cv_state_t;

  dtc_cv_state_t state_reg;
  dtc_cv_state_t state_next;
  logic [31:0] conv_cnt_reg;
  logic [31:0] conv_cnt_next;
  logic [31:0] rate_cnt_reg;
  logic [31:0] rate_cnt_next;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [31:0] conv_last = 32'(CONV_CYCLES - 1);
  // interval runs from one sequence to 128 sequences long
  wire [31:0] interval_last = 32'((CONV_CYCLES << (RATE_MAX - rate_i)) - 1);
  wire rate_due = !standby_i && (rate_cnt_reg >= interval_last);
  wire idle = (state_reg == CV_IDLE);
  wire start = idle && (rate_due || oneshot_i);
  wire abort = !idle && standby_cmd_i && !oneshot_i;
  wire finish = !idle && !abort && (conv_cnt_reg == conv_last);

  assign busy_o = !idle;
  assign start_o = start;
  assign done_o = finish;

  always_comb
  begin
    state_next = state_reg;
    conv_cnt_next = conv_cnt_reg;
    rate_cnt_next = rate_cnt_reg;
    if (start)
    begin
      state_next = CV_RUN;
      conv_cnt_next = 32'h0;
    end
    else if (abort || finish)
      state_next = CV_IDLE;
    else if (!idle)
      conv_cnt_next = conv_cnt_reg + 32'h1;
    // standby parks the timer as expired so leaving standby starts at once
    if (standby_i)
      rate_cnt_next = interval_last;
    else if (start)
      rate_cnt_next = 32'h0;
    else if (!rate_due)
      rate_cnt_next = rate_cnt_reg + 32'h1;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= CV_IDLE;
      conv_cnt_reg <= 32'h0;
      rate_cnt_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      conv_cnt_reg <= conv_cnt_next;
      rate_cnt_reg <= rate_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_abort;
    abort |=> !busy_o && !done_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop sequence");

  property p_auto;
    (idle && !standby_i && rate_cnt_reg >= interval_last) |=> busy_o;
  endproperty
  a_auto: assert property (p_auto) else $error("free run did not start");

  property p_oneshot;
    (idle && oneshot_i) |=> busy_o && conv_cnt_reg == 32'h0;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot ignored");

  property p_standby;
    (standby_i && idle && !oneshot_i) |=> !busy_o;
  endproperty
  a_standby: assert property (p_standby) else $error("started in standby");

  property p_length;
    (busy_o && !abort && conv_cnt_reg < conv_last) |=> busy_o && !$stable(conv_cnt_reg);
  endproperty
  a_length: assert property (p_length) else $error("sequence ended early");

  c_abort: cover property (abort);
  c_oneshot_standby: cover property (standby_i && oneshot_i && idle ##1 busy_o);
endmodule

// ==== sim/dtc_host_model.sv ====
// smbus host model: start, stop, byte-level transfers
// assumes an open-drain wire resolved by the bench, pulled high
`timescale 1ns/100ps
module dtc_host_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter int HALF = 8
) (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int nak_cnt = 0;
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // works from idle and as repeated start
  task automatic bus_start();
    sda_oe_o = 1'b0;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    sda_oe_o = 1'b1;
    tick(HALF);
    scl_o = 1'b0;
  endtask
  task automatic bus_stop();
    sda_oe_o = 1'b1;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    sda_oe_o = 1'b0;
    tick(HALF);
  endtask
  // data set on the scl fall, sampled at the end of scl high
  task automatic bit_xfer(input logic b, output logic r);
    sda_oe_o = ~b;
    tick(HALF);
    scl_o = 1'b1;
    tick(HALF);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    if (r !== 1'b0) nak_cnt++;
  endtask
  // always not-acks: one byte per transfer
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(1'b1, r);
  endtask
  task automatic wr_byte(input logic [7:0] c, input logic [7:0] d);
    bus_start();
    put({ADDR, 1'b0});
    put(c);
    put(d);
    bus_stop();
  endtask
  task automatic send_byte(input logic [7:0] c);
    bus_start();
    put({ADDR, 1'b0});
    put(c);
    bus_stop();
  endtask
  task automatic rd_byte(input logic [7:0] c, output logic [7:0] d);
    bus_start();
    put({ADDR, 1'b0});
    put(c);
    bus_start();
    put({ADDR, 1'b1});
    get(d);
    bus_stop();
  endtask
  task automatic rcv_byte(output logic [7:0] d);
    bus_start();
    put({ADDR, 1'b1});
    get(d);
    bus_stop();
  endtask
endmodule

// ==== sim/tb_top.sv ====
// bench for the temperature readout, driven through the host model
// assumes shortened sequence and timeout lengths
`timescale 1ns/100ps
module tb_top;
  import dtc_pkg::*;
  localparam int unsigned CONV = 2000;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic scl, host_oe, dev_oe, sda_line, busy;
  dtc_meas_t meas = '0;
  int error_cnt = 0;
  int tests_run = 0;
  assign sda_line = ~(host_oe | dev_oe);
  always #25 clock_i = ~clock_i;
  dtc_readout #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(200)) dtc_readout_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(), .sda_oe_o(dev_oe), .meas_i(meas), .conv_start_o(), .conv_busy_o(busy));
  dtc_host_model dtc_host_model_i (
    .clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_oe_o(host_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    logic [7:0] r;
    dtc_host_model_i.rd_byte(c, r);
    chk({8'h00, r & m}, {8'h00, exp});
  endtask
  // bounded wait for one whole sequence, returns busy length
  task automatic wait_done(output int hi);
    int n;
    n = 0;
    hi = 0;
    while (busy !== 1'b1 && n < 6000) begin @(negedge clock_i); n++; end
    while (busy === 1'b1 && n < 6000) begin @(negedge clock_i); n++; hi++; end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clock_i);
    error_cnt++;
    $display("BAD %0t watchdog", $time);
    close_out();
  end
  initial
  begin
    int hi;
    logic seen;
    logic [7:0] r;
    meas = '{fault: 1'b0, local_raw: 12'h0c9, remote_raw: 12'h327};
    repeat (10) @(negedge clock_i);
    resetn_i = 1'b1;
    wait_done(hi);
    chk(16'(hi), 16'(CONV));
    rd(REG_LOCAL_INT, 8'h19);
    rd(REG_LOCAL_FRAC, 8'h20);
    rd(REG_REMOTE_INT, 8'h64);
    rd(REG_REMOTE_FRAC, 8'he0);
    wait_done(hi);
    meas.local_raw = 12'h1f8;
    rd(REG_STATUS, 8'h80, 8'h80);
    rd(REG_LOCAL_INT, 8'h19);
    // standby lands while the free-run sequence is still busy
    dtc_host_model_i.wr_byte(REG_CONFIG_WR, 8'h40);
    seen = 1'b0;
    repeat (5000) begin @(negedge clock_i); seen |= busy; end
    chk({15'h0, seen}, 16'h0);
    rd(REG_LOCAL_INT, 8'h19);
    rd(REG_CONFIG_RD, 8'h40);
    meas = '{fault: 1'b1, local_raw: 12'hfc0, remote_raw: 12'h327};
    // the sequence starts before the stop, so its length is timed alongside
    fork
      dtc_host_model_i.send_byte(REG_ONESHOT);
      wait_done(hi);
    join
    chk(16'(hi), 16'(CONV));
    rd(REG_REMOTE_INT, 8'hff);
    dtc_host_model_i.rcv_byte(r);
    chk({8'h00, r}, 16'h00ff);
    rd(REG_LOCAL_INT, 8'h00);
    rd(REG_LOCAL_FRAC, 8'h00);
    chk(16'(dtc_host_model_i.nak_cnt), 16'h0);
    close_out();
  end
endmodule
